// >>> rtl/spi_map_pkg.sv
// Constants for the shared interrupt line map of one chip window.
// Assumes all sources and the distributor share one clock.
package spi_map_pkg;
  localparam int LINES_PER_CHIP = 480;
  localparam int LINE_GRANULE = 32;
  localparam int WINDOW_FIRST = 50;
  localparam int WINDOW_LINES = 32;
  // Offsets from chip_base_interrupt_id
  localparam int OFS_MPAM_S = 50;
  localparam int OFS_RSVD_A_LO = 51;
  localparam int OFS_RSVD_A_HI = 63;
  localparam int OFS_ADDR_XLATE = 64;
  localparam int OFS_TRACE_BUF = 65;
  localparam int OFS_MBOX_NS = 66;
  localparam int OFS_MBOX_S = 67;
  localparam int OFS_RSVD_B_LO = 68;
  localparam int OFS_RSVD_B_HI = 71;
  localparam int OFS_SYNC = 72;
  localparam int OFS_XTRIG0 = 73;
  localparam int OFS_XTRIG1 = 74;
  localparam int OFS_WDOG_S = 75;
  localparam int OFS_TIMER_S = 76;
  localparam int OFS_TIMER_NS = 77;
  localparam int OFS_NSWDOG0 = 78;
  localparam int OFS_NSWDOG1 = 79;
  localparam int OFS_UART_NS = 80;
  localparam int OFS_UART_S = 81;
  // Trigger: 1 = edge (rising), 0 = level; polarity: 1 = active high
  localparam logic [31:0] TRIG_EDGE_MASK = 32'h01C0_0000;
  localparam logic [31:0] POL_HIGH_MASK = 32'hFFFF_FFFF;
  localparam logic [31:0] RSVD_MASK = 32'h003C_3FFE;
endpackage

// >>> rtl/spi_line_cell.sv
// One shared interrupt line: registers the source and adapts it to its trigger type.
// Assumes the source is synchronous to clk.
`timescale 1ns/10ps
module spi_line_cell #(
  parameter bit IS_EDGE = 1'b0,
  parameter bit IS_RSVD = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Source and line
  input wire logic src,
  output logic line
);
  logic srcDly_ff, nxt_srcDly;
  logic line_ff, nxt_line;

  always_comb begin
    nxt_srcDly = src;
    if (IS_RSVD) begin
      nxt_line = 1'b0;
    end else if (IS_EDGE) begin
      // Rising edge gives a one-cycle request
      nxt_line = src & ~srcDly_ff;
    end else begin
      nxt_line = src;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      srcDly_ff <= 1'b0;
      line_ff <= 1'b0;
    end else begin
      srcDly_ff <= nxt_srcDly;
      line_ff <= nxt_line;
    end
  end

  assign line = line_ff;
endmodule

// >>> rtl/shared_interrupt_line_map.sv
// Maps peripheral interrupt sources onto one window of shared distributor lines.
// Assumes sources and distributor run on clk; chip base id is a parameter.
// Overview of operation
// - Non-secure mailbox receive interrupt drives offset 66
// - Secure mailbox receive interrupt drives offset 67
// - Secure reference timer interrupt drives offset 76
// - Non-secure reference timer interrupt drives offset 77
// - Lines numbered from chip base, 480 each
// - Each line reports its trigger and polarity
`timescale 1ns/10ps
module shared_interrupt_line_map
  import spi_map_pkg::*;
#(
  parameter int CHIP_BASE_ID = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level sources, active high
  input wire logic mpamErrSecure,
  input wire logic addrTranslateErr,
  input wire logic traceBufIrq,
  input wire logic mboxRxNonSecure,
  input wire logic mboxRxSecure,
  input wire logic secureWatchdog,
  input wire logic refTimerSecure,
  input wire logic refTimerNonSecure,
  input wire logic nsWatchdog0,
  input wire logic nsWatchdog1,
  input wire logic uartNonSecure,
  input wire logic uartSecure,
  // Edge sources, rising edge
  input wire logic traceSyncIrq,
  input wire logic crossTrig0,
  input wire logic crossTrig1,
  // Distributor side
  output logic [WINDOW_LINES-1:0] spiLines,
  output logic [WINDOW_LINES-1:0] spiEdgeCfg,
  output logic [WINDOW_LINES-1:0] spiActiveHighCfg,
  output logic [12:0] windowBaseId
);
  // Bit position inside the window for every wired source
  localparam int LN_MPAM_S = OFS_MPAM_S - WINDOW_FIRST;
  localparam int LN_ADDR_XLATE = OFS_ADDR_XLATE - WINDOW_FIRST;
  localparam int LN_TRACE_BUF = OFS_TRACE_BUF - WINDOW_FIRST;
  localparam int LN_MBOX_NS = OFS_MBOX_NS - WINDOW_FIRST;
  localparam int LN_MBOX_S = OFS_MBOX_S - WINDOW_FIRST;
  localparam int LN_SYNC = OFS_SYNC - WINDOW_FIRST;
  localparam int LN_XTRIG0 = OFS_XTRIG0 - WINDOW_FIRST;
  localparam int LN_XTRIG1 = OFS_XTRIG1 - WINDOW_FIRST;
  localparam int LN_WDOG_S = OFS_WDOG_S - WINDOW_FIRST;
  localparam int LN_TIMER_S = OFS_TIMER_S - WINDOW_FIRST;
  localparam int LN_TIMER_NS = OFS_TIMER_NS - WINDOW_FIRST;
  localparam int LN_NSWDOG0 = OFS_NSWDOG0 - WINDOW_FIRST;
  localparam int LN_NSWDOG1 = OFS_NSWDOG1 - WINDOW_FIRST;
  localparam int LN_UART_NS = OFS_UART_NS - WINDOW_FIRST;
  localparam int LN_UART_S = OFS_UART_S - WINDOW_FIRST;

  // Window stays inside the chip's 480-line allocation
  localparam int WINDOW_BASE = CHIP_BASE_ID + WINDOW_FIRST;

  logic [WINDOW_LINES-1:0] edgeCfg_ff, nxt_edgeCfg;
  logic [WINDOW_LINES-1:0] activeHighCfg_ff, nxt_activeHighCfg;
  logic [12:0] baseId_ff, nxt_baseId;

  // Configuration is fixed; registered only so the outputs leave from flops
  always_comb begin
    nxt_edgeCfg = TRIG_EDGE_MASK;
    nxt_activeHighCfg = POL_HIGH_MASK;
    nxt_baseId = 13'(WINDOW_BASE);
  end

  // No reset needed: the values are constant and valid from the first edge
  always_ff @(posedge clk) begin
    edgeCfg_ff <= nxt_edgeCfg;
    activeHighCfg_ff <= nxt_activeHighCfg;
    baseId_ff <= nxt_baseId;
  end

  assign spiEdgeCfg = edgeCfg_ff;
  assign spiActiveHighCfg = activeHighCfg_ff;
  assign windowBaseId = baseId_ff;

  // One cell per wired source; each cell takes its trigger type from the mask,
  // so the line and the configuration reported for it cannot drift apart.
  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_MPAM_S]),
    .IS_RSVD(RSVD_MASK[LN_MPAM_S])
  ) mpamSecureCell (
    .clk(clk),
    .rst(rst),
    .src(mpamErrSecure),
    .line(spiLines[LN_MPAM_S])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_ADDR_XLATE]),
    .IS_RSVD(RSVD_MASK[LN_ADDR_XLATE])
  ) addrXlateCell (
    .clk(clk),
    .rst(rst),
    .src(addrTranslateErr),
    .line(spiLines[LN_ADDR_XLATE])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_TRACE_BUF]),
    .IS_RSVD(RSVD_MASK[LN_TRACE_BUF])
  ) traceBufCell (
    .clk(clk),
    .rst(rst),
    .src(traceBufIrq),
    .line(spiLines[LN_TRACE_BUF])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_MBOX_NS]),
    .IS_RSVD(RSVD_MASK[LN_MBOX_NS])
  ) mboxNsCell (
    .clk(clk),
    .rst(rst),
    .src(mboxRxNonSecure),
    .line(spiLines[LN_MBOX_NS])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_MBOX_S]),
    .IS_RSVD(RSVD_MASK[LN_MBOX_S])
  ) mboxSecureCell (
    .clk(clk),
    .rst(rst),
    .src(mboxRxSecure),
    .line(spiLines[LN_MBOX_S])
  );

  // Edge sources: a source held high gives a single request only
  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_SYNC]),
    .IS_RSVD(RSVD_MASK[LN_SYNC])
  ) traceSyncCell (
    .clk(clk),
    .rst(rst),
    .src(traceSyncIrq),
    .line(spiLines[LN_SYNC])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_XTRIG0]),
    .IS_RSVD(RSVD_MASK[LN_XTRIG0])
  ) crossTrig0Cell (
    .clk(clk),
    .rst(rst),
    .src(crossTrig0),
    .line(spiLines[LN_XTRIG0])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_XTRIG1]),
    .IS_RSVD(RSVD_MASK[LN_XTRIG1])
  ) crossTrig1Cell (
    .clk(clk),
    .rst(rst),
    .src(crossTrig1),
    .line(spiLines[LN_XTRIG1])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_WDOG_S]),
    .IS_RSVD(RSVD_MASK[LN_WDOG_S])
  ) secureWdogCell (
    .clk(clk),
    .rst(rst),
    .src(secureWatchdog),
    .line(spiLines[LN_WDOG_S])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_TIMER_S]),
    .IS_RSVD(RSVD_MASK[LN_TIMER_S])
  ) timerSecureCell (
    .clk(clk),
    .rst(rst),
    .src(refTimerSecure),
    .line(spiLines[LN_TIMER_S])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_TIMER_NS]),
    .IS_RSVD(RSVD_MASK[LN_TIMER_NS])
  ) timerNsCell (
    .clk(clk),
    .rst(rst),
    .src(refTimerNonSecure),
    .line(spiLines[LN_TIMER_NS])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_NSWDOG0]),
    .IS_RSVD(RSVD_MASK[LN_NSWDOG0])
  ) nsWdog0Cell (
    .clk(clk),
    .rst(rst),
    .src(nsWatchdog0),
    .line(spiLines[LN_NSWDOG0])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_NSWDOG1]),
    .IS_RSVD(RSVD_MASK[LN_NSWDOG1])
  ) nsWdog1Cell (
    .clk(clk),
    .rst(rst),
    .src(nsWatchdog1),
    .line(spiLines[LN_NSWDOG1])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_UART_NS]),
    .IS_RSVD(RSVD_MASK[LN_UART_NS])
  ) uartNsCell (
    .clk(clk),
    .rst(rst),
    .src(uartNonSecure),
    .line(spiLines[LN_UART_NS])
  );

  spi_line_cell #(
    .IS_EDGE(TRIG_EDGE_MASK[LN_UART_S]),
    .IS_RSVD(RSVD_MASK[LN_UART_S])
  ) uartSecureCell (
    .clk(clk),
    .rst(rst),
    .src(uartSecure),
    .line(spiLines[LN_UART_S])
  );

  // Reserved positions get a cell tied low, so every window bit has one flop
  // driver and the distributor never sees a request there.
  genvar i;
  generate
    for (i = 0; i < WINDOW_LINES; i++) begin : g_rsvd
      if (RSVD_MASK[i]) begin : g_tie
        spi_line_cell #(
          .IS_EDGE(TRIG_EDGE_MASK[i]),
          .IS_RSVD(1'b1)
        ) rsvdCell (
          .clk(clk),
          .rst(rst),
          .src(1'b0),
          .line(spiLines[i])
        );
      end
    end
  endgenerate
endmodule

// >>> test/line_map_chk.sv
// Port checker for the shared line map.
// Assumes one clock with a sync reset.
`timescale 1ns/10ps
module line_map_chk import spi_map_pkg::*; #(parameter int CHIP_BASE_ID = 32) (
  input wire logic clk, rst, mboxRxNonSecure, mboxRxSecure, crossTrig0,
  input wire logic refTimerSecure, refTimerNonSecure,
  input wire logic [31:0] spiLines, spiEdgeCfg, spiActiveHighCfg,
  input wire logic [12:0] windowBaseId
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  mbox_ns_a: assert property (!$past(rst) |-> spiLines[16] == $past(mboxRxNonSecure))
    else $error("mbox ns line");
  mbox_s_a: assert property (!$past(rst) |-> spiLines[17] == $past(mboxRxSecure))
    else $error("mbox s line");
  tmr_s_a: assert property (!$past(rst) |-> spiLines[26] == $past(refTimerSecure))
    else $error("timer s line");
  tmr_ns_a: assert property (!$past(rst) |-> spiLines[27] == $past(refTimerNonSecure))
    else $error("timer ns line");
  base_id_a: assert property (windowBaseId == 13'(CHIP_BASE_ID + 50))
    else $error("base id");
  trig_cfg_a: assert property (spiEdgeCfg == 32'h01C0_0000 && spiActiveHighCfg == '1)
    else $error("trigger cfg");
  edge_pulse_a: assert property ($rose(crossTrig0) |=> spiLines[23] ##1 !spiLines[23])
    else $error("edge pulse");
  rsvd_low_a: assert property ((spiLines & 32'h003C_3FFE) == 32'h0)
    else $error("reserved line");
endmodule
bind shared_interrupt_line_map line_map_chk #(.CHIP_BASE_ID(CHIP_BASE_ID)) line_map_chk_inst (.*);

// >>> test/dist_model.sv
// Distributor stand-in: counts pulses on edge-configured lines.
// Assumes lines are synchronous to clk.
`timescale 1ns/10ps
module dist_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] lines,
  input wire logic [31:0] edgeCfg,
  output logic [31:0] pulses_ff
);
  logic [31:0] nxt_pulses;
  always_comb nxt_pulses = rst ? 32'h0 : pulses_ff + 32'($countones(lines & edgeCfg));
  always_ff @(posedge clk) pulses_ff <= nxt_pulses;
endmodule

// >>> test/tb.sv
// Bench for the shared line map, chip base 512.
// Assumes the checker is bound in.
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst = 1;
  logic [14:0] s = '0;
  logic [31:0] lines, ecfg, hcfg, pulses;
  logic [12:0] bid;
  int failures = 0, n_tests = 0;
  int ofs[15] = '{50, 64, 65, 66, 67, 75, 76, 77, 78, 79, 80, 81, 72, 73, 74};
  shared_interrupt_line_map #(.CHIP_BASE_ID(512)) shared_interrupt_line_map_inst (
    .clk(clk), .rst(rst), .mpamErrSecure(s[0]), .addrTranslateErr(s[1]), .traceBufIrq(s[2]),
    .mboxRxNonSecure(s[3]), .mboxRxSecure(s[4]), .secureWatchdog(s[5]), .refTimerSecure(s[6]),
    .refTimerNonSecure(s[7]), .nsWatchdog0(s[8]), .nsWatchdog1(s[9]), .uartNonSecure(s[10]),
    .uartSecure(s[11]), .traceSyncIrq(s[12]), .crossTrig0(s[13]), .crossTrig1(s[14]),
    .spiLines(lines), .spiEdgeCfg(ecfg), .spiActiveHighCfg(hcfg), .windowBaseId(bid));
  dist_model dist_model_inst (.clk(clk), .rst(rst), .lines(lines), .edgeCfg(ecfg),
    .pulses_ff(pulses));
  initial forever #10 clk = ~clk;
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_lines();
    logic [31:0] m, e;
    e = '0;
    for (int i = 0; i < 15; i++) begin
      m = 32'h1 << (ofs[i] - 50);
      if (i > 11) e |= m;
      s[i] = 1;
      @(posedge clk) #1 chk("rise", lines, m);
      @(posedge clk) #1 chk("hold", lines, i < 12 ? m : 32'h0);
      s[i] = 0;
      @(posedge clk) #1 chk("fall", lines, 32'h0);
    end
    chk("pulses", pulses, 32'h3);
    chk("edgecfg", ecfg, e);
    chk("polcfg", hcfg, 32'hFFFF_FFFF);
    chk("base", 32'(bid), 32'(512 + 50));
    $display("t_lines done");
  endtask
  task automatic t_rsvd();
    logic [31:0] used;
    used = '0;
    foreach (ofs[i]) used |= 32'h1 << (ofs[i] - 50);
    s = '1;
    @(posedge clk) #1 chk("rsvd", lines & ~used, 32'h0);
    chk("alllive", lines, used);
    s = '0;
    $display("t_rsvd done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 0;
    @(posedge clk) #1;
    t_lines();
    t_rsvd();
    conclude();
  end
  initial begin
    #5000;
    failures++;
    conclude();
  end
endmodule
